// >>> cis_extractor.sv
`include "cis_defines.svh"

module cis_extractor
   import cis_pkg::*;
#(
   parameter int unsigned NUM_CH    = 5,
   parameter int unsigned ADDR_W    = 12,
   parameter int unsigned MS_CYCLES = `CIS_MS_NS / `CIS_CLK_NS
) (
   input  wire logic                     core_clk_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     psel_in,
   input  wire logic                     penable_in,
   input  wire logic                     pwrite_in,
   input  wire logic [ADDR_W-1:0]        paddr_in,
   input  wire logic [31:0]              pwdata_in,
   output      logic [31:0]              prdata_out,
   output      logic                     pready_out,
   output      logic                     pslverr_out,
   input  wire logic                     rx_valid_in,
   input  wire cis_frame_t               rx_frame_in,
   input  wire logic                     tx_valid_in,
   input  wire cis_frame_t               tx_frame_in,
   output      cis_signal_t [NUM_CH-1:0] sig_out,
   output      logic [NUM_CH-1:0]        sig_update_out
);

   // Whole state of the block except the reset synchroniser
   typedef struct packed {
      cis_chan_t [NUM_CH-1:0] ch;
      logic                   tx_pend;
      cis_frame_t             tx_frame;
      logic [31:0]            ms_cnt;
      logic                   ms_tick;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
   } cis_regs_t;

   localparam cis_cfg_t CFG_RST = '{
      kind:     CIS_UNDEF,
      filt:     1'b0,
      byte_pos: `CIS_POS_RST,
      bit_pos:  `CIS_POS_RST,
      sel_addr: `CIS_ADDR_RST,
      pgn:      `CIS_PGN_RST,
      res:      `CIS_RES_RST,
      ofs:      `CIS_OFS_RST,
      max:      `CIS_MAX_RST,
      min:      `CIS_MIN_RST,
      art:      `CIS_ART_RST
   };
   localparam cis_signal_t SIG_NA = '{state: CIS_NOT_AVAIL, code: 26'h0, value: 17'h0};
   localparam cis_chan_t CH_RST = '{cfg: CFG_RST, sig: SIG_NA, age: 14'h0, upd: 1'b0};
   localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

   logic [1:0]  rst_sync;              // Reset release synchroniser
   logic        rst_n;                 // Synchronised reset
   cis_regs_t   q;                     // Registered state
   cis_regs_t   next_q;                // Next state
   logic        cur_valid;             // A frame is offered this cycle
   cis_frame_t  cur;                   // Frame offered to all channels
   logic        take_tx_now;           // Loopback frame goes straight in
   logic [NUM_CH-1:0] match;           // Channel accepts the frame
   cis_signal_t [NUM_CH-1:0] dec;      // Decoded signal per channel

   // Clamp a 1..8 position setpoint
   function automatic logic [3:0] clamp_pos(input logic [3:0] v);
      logic [3:0] r;
      r = v;
      if (v == 4'h0) begin
         r = `CIS_POS_RST;
      end else if (v > `CIS_POS_MAX) begin
         r = `CIS_POS_MAX;
      end
      return r;
   endfunction

   // Scale and normalize a continuous code into 0..1 in Q1.16
   function automatic logic [16:0] normalize(input logic [31:0] raw, input cis_cfg_t c);
      logic signed [65:0] scaled;
      logic signed [65:0] num;
      logic signed [65:0] den;
      logic [48:0]        quot;
      logic [16:0]        r;
      scaled = 66'($signed({1'b0, raw})) * 66'($signed(c.res)) + 66'($signed(c.ofs));
      num    = scaled - 66'($signed(c.min));
      den    = 66'($signed(c.max)) - 66'($signed(c.min));
      quot   = 49'h0;
      r      = 17'h0;
      // Degenerate span gives zero rather than a divide by zero
      if (den <= 66'sh0 || num <= 66'sh0) begin
         r = 17'h0;
      end else if (num >= den) begin
         r = `CIS_NORM_ONE;
      end else begin
         quot = {num[32:0], 16'h0} / {16'h0, den[32:0]};
         r    = quot[16:0];
      end
      return r;
   endfunction

   // Map a raw field to state, code and value
   function automatic cis_signal_t decode(input logic [63:0] bytes,
                                          input logic [7:0] bits, input cis_cfg_t c);
      cis_signal_t s;
      logic [31:0] raw;
      logic [7:0]  top;
      logic [23:0] low;
      logic [1:0]  spec;
      s    = SIG_NA;
      raw  = bytes[31:0];
      top  = 8'h0;
      low  = 24'h0;
      case (c.kind)
         CIS_BYTE1: begin
            raw = {24'h0, bytes[7:0]};
            top = bytes[7:0];
         end
         CIS_BYTE2: begin
            raw = {16'h0, bytes[15:0]};
            top = bytes[15:8];
            low = {16'h0, bytes[7:0]};
         end
         CIS_BYTE4: begin
            top = bytes[31:24];
            low = bytes[23:0];
         end
         default: begin
            raw = 32'h0;
         end
      endcase
      spec = 2'(top - `CIS_TOP_SPECIAL);
      case (c.kind)
         CIS_BIT1: begin
            // Single bit is always data
            s = '{state: CIS_VALID, code: 26'h0, value: {bits[0], 16'h0}};
         end
         CIS_BIT2: begin
            if (bits[1] == 1'b0) begin
               s = '{state: CIS_VALID, code: 26'h0, value: {bits[0], 16'h0}};
            end else if (bits[1:0] == 2'(`CIS_D2_ERROR)) begin
               s = '{state: CIS_ERROR, code: 26'h0, value: 17'h0};
            end else begin
               s = SIG_NA;
            end
         end
         CIS_BIT4: begin
            if (bits[3:0] < `CIS_D4_SPEC_MIN) begin
               s = '{state: CIS_VALID, code: 26'h0, value: {bits[0], 16'h0}};
            end else if (bits[3:0] < `CIS_D4_ERROR) begin
               s = '{state: CIS_SPECIAL, code: 26'(bits[3:0] - `CIS_D4_SPEC_MIN),
                     value: 17'h0};
            end else if (bits[3:0] == `CIS_D4_ERROR) begin
               s = '{state: CIS_ERROR, code: 26'h0, value: 17'h0};
            end else begin
               s = SIG_NA;
            end
         end
         CIS_BYTE1, CIS_BYTE2, CIS_BYTE4: begin
            if (top <= `CIS_TOP_VALID_MAX) begin
               s = '{state: CIS_VALID, code: 26'h0, value: normalize(raw, c)};
            end else if (top <= `CIS_TOP_SPEC_MAX) begin
               // Special index stacked above the low bytes
               s.state = CIS_SPECIAL;
               s.value = 17'h0;
               case (c.kind)
                  CIS_BYTE1: s.code = {24'h0, spec};
                  CIS_BYTE2: s.code = {16'h0, spec, low[7:0]};
                  default:   s.code = {spec, low};
               endcase
            end else if (top == `CIS_TOP_ERROR) begin
               s = '{state: CIS_ERROR, code: {2'h0, low}, value: 17'h0};
            end else begin
               s = SIG_NA;
            end
         end
         default: begin
            s = SIG_NA;
         end
      endcase
      return s;
   endfunction

   // Frame source: bus frames first, a loopback frame meeting one waits in the pending slot
   assign take_tx_now = !rx_valid_in && !q.tx_pend && tx_valid_in;
   assign cur_valid   = rx_valid_in || q.tx_pend || tx_valid_in;
   assign cur         = rx_valid_in ? rx_frame_in : (q.tx_pend ? q.tx_frame : tx_frame_in);

   // One extractor per channel
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         cis_cfg_t    c;        // Setpoints of this channel
         logic [2:0]  byte_idx; // Zero-based byte position
         logic [2:0]  bit_idx;  // Zero-based bit position
         logic [63:0] bytes;    // Data shifted to the field's LSB byte
         logic [7:0]  bits;     // Selected byte shifted to field LSB
         assign c        = q.ch[gi].cfg;
         assign byte_idx = 3'(c.byte_pos - 4'h1);
         assign bit_idx  = 3'(c.bit_pos - 4'h1);
         assign bytes    = cur.data >> {byte_idx, 3'b000};
         assign bits     = bytes[7:0] >> bit_idx;
         // Undefined or unknown kinds never accept
         assign match[gi] = cur_valid && cur.single && (cur.pgn == c.pgn)
                            && (!c.filt || (cur.src == c.sel_addr))
                            && (c.kind != CIS_UNDEF) && (c.kind <= CIS_BYTE4);
         assign dec[gi] = decode(bytes, bits, c);
      end
   endgenerate

   // Next-state logic
   always_comb begin
      logic [ADDR_W-1:0] ch_sel;
      logic [5:0]        off;
      logic              hit;
      logic              wr;
      ch_sel = paddr_in >> `CIS_CH_SHIFT;
      off    = paddr_in[5:0];
      // APB decode
      hit = (ch_sel < ADDR_W'(NUM_CH)) && (off <= `CIS_OFF_VALUE) && (off[1:0] == 2'b00);
      wr  = psel_in && penable_in && q.pready && pwrite_in && hit;
      next_q = q;
      // Loopback pending slot; a second loopback frame meeting a bus frame while it is full overwrites it
      if (tx_valid_in && !take_tx_now) begin
         next_q.tx_pend  = 1'b1;
         next_q.tx_frame = tx_frame_in;
      end else if (!rx_valid_in && q.tx_pend) begin
         next_q.tx_pend = 1'b0;
      end
      // Millisecond enable
      next_q.ms_tick = 1'b0;
      if (q.ms_cnt >= MS_LAST) begin
         next_q.ms_cnt  = 32'h0;
         next_q.ms_tick = 1'b1;
      end else begin
         next_q.ms_cnt = q.ms_cnt + 32'h1;
      end
      // Signal update and autoreset per channel
      for (int i = 0; i < NUM_CH; i++) begin
         next_q.ch[i].upd = 1'b0;
         if (match[i]) begin
            next_q.ch[i].sig = dec[i];
            next_q.ch[i].age = 14'h0;
            next_q.ch[i].upd = 1'b1;
         end else if (q.ms_tick && (q.ch[i].cfg.art != 14'h0)
                      && (q.ch[i].sig.state != CIS_NOT_AVAIL)) begin
            if (q.ch[i].age + 14'h1 >= q.ch[i].cfg.art) begin
               next_q.ch[i].sig = SIG_NA;
               next_q.ch[i].age = 14'h0;
               next_q.ch[i].upd = 1'b1;
            end else begin
               next_q.ch[i].age = q.ch[i].age + 14'h1;
            end
         end
      end
      // Setup phase: capture read data and answer in the access phase
      next_q.pready  = psel_in && !penable_in;
      next_q.pslverr = psel_in && !penable_in && !hit;
      next_q.prdata  = 32'h0;
      if (psel_in && !penable_in && hit) begin
         case (off)
            `CIS_OFF_CFG: next_q.prdata = {8'h0, q.ch[ch_sel].cfg.sel_addr, 4'h0,
                                           q.ch[ch_sel].cfg.bit_pos,
                                           q.ch[ch_sel].cfg.byte_pos,
                                           q.ch[ch_sel].cfg.filt, q.ch[ch_sel].cfg.kind};
            `CIS_OFF_PGN:    next_q.prdata = {14'h0, q.ch[ch_sel].cfg.pgn};
            `CIS_OFF_RES:    next_q.prdata = q.ch[ch_sel].cfg.res;
            `CIS_OFF_OFS:    next_q.prdata = q.ch[ch_sel].cfg.ofs;
            `CIS_OFF_MAX:    next_q.prdata = q.ch[ch_sel].cfg.max;
            `CIS_OFF_MIN:    next_q.prdata = q.ch[ch_sel].cfg.min;
            `CIS_OFF_ART:    next_q.prdata = {18'h0, q.ch[ch_sel].cfg.art};
            `CIS_OFF_STATUS: next_q.prdata = {4'h0, q.ch[ch_sel].sig.code,
                                              q.ch[ch_sel].sig.state};
            `CIS_OFF_VALUE:  next_q.prdata = {15'h0, q.ch[ch_sel].sig.value};
            default:         next_q.prdata = 32'h0;
         endcase
      end
      // Access phase write; out-of-range setpoints are clamped, an unknown kind becomes CIS_UNDEF
      if (wr) begin
         case (off)
            `CIS_OFF_CFG: begin
               next_q.ch[ch_sel].cfg.kind = (pwdata_in[2:0] > 3'(CIS_BYTE4)) ? CIS_UNDEF
                                            : cis_kind_t'(pwdata_in[2:0]);
               next_q.ch[ch_sel].cfg.filt     = pwdata_in[`CIS_CFG_FILT_BIT];
               next_q.ch[ch_sel].cfg.byte_pos = clamp_pos(pwdata_in[`CIS_CFG_BYTE_LSB +: 4]);
               next_q.ch[ch_sel].cfg.bit_pos  = clamp_pos(pwdata_in[`CIS_CFG_BIT_LSB +: 4]);
               next_q.ch[ch_sel].cfg.sel_addr =
                  (pwdata_in[`CIS_CFG_ADDR_LSB +: 8] > `CIS_ADDR_MAX) ? `CIS_ADDR_MAX
                  : pwdata_in[`CIS_CFG_ADDR_LSB +: 8];
            end
            `CIS_OFF_PGN: next_q.ch[ch_sel].cfg.pgn = pwdata_in[17:0];
            `CIS_OFF_RES: next_q.ch[ch_sel].cfg.res = pwdata_in;
            `CIS_OFF_OFS: next_q.ch[ch_sel].cfg.ofs = pwdata_in;
            `CIS_OFF_MAX: next_q.ch[ch_sel].cfg.max = pwdata_in;
            `CIS_OFF_MIN: next_q.ch[ch_sel].cfg.min = pwdata_in;
            `CIS_OFF_ART: begin
               next_q.ch[ch_sel].cfg.art = (pwdata_in > 32'(`CIS_ART_MAX)) ? `CIS_ART_MAX
                                           : pwdata_in[13:0];
            end
            default: begin
               // Status and value are read only
               next_q.ch[ch_sel].cfg = q.ch[ch_sel].cfg;
            end
         endcase
      end
   end

   // Reset release synchroniser
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // State register
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            q.ch[i] <= CH_RST;
         end
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from the state register
   assign prdata_out  = q.prdata;
   assign pready_out  = q.pready;
   assign pslverr_out = q.pslverr;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         sig_out[i]        = q.ch[i].sig;
         sig_update_out[i] = q.ch[i].upd;
      end
   end

endmodule

// >>> cis_defines.svh
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH

// Per-channel register window, byte offsets within one channel
`define CIS_CH_SHIFT      6
`define CIS_OFF_CFG       6'h00
`define CIS_OFF_PGN       6'h04
`define CIS_OFF_RES       6'h08
`define CIS_OFF_OFS       6'h0C
`define CIS_OFF_MAX       6'h10
`define CIS_OFF_MIN       6'h14
`define CIS_OFF_ART       6'h18
`define CIS_OFF_STATUS    6'h1C
`define CIS_OFF_VALUE     6'h20

// Control word field positions
`define CIS_CFG_KIND_LSB  0
`define CIS_CFG_FILT_BIT  3
`define CIS_CFG_BYTE_LSB  4
`define CIS_CFG_BIT_LSB   8
`define CIS_CFG_ADDR_LSB  16

// Reset values and limits of the setpoints
`define CIS_PGN_RST       18'h0FF00
`define CIS_ADDR_RST      8'h00
`define CIS_ADDR_MAX      8'hFD
`define CIS_POS_RST       4'h1
`define CIS_POS_MAX       4'h8
`define CIS_RES_RST       32'h00010000
`define CIS_OFS_RST       32'h00000000
`define CIS_MAX_RST       32'h00010000
`define CIS_MIN_RST       32'h00000000
`define CIS_ART_RST       14'h01F4
`define CIS_ART_MAX       14'h2710

// Code ranges of continuous and discrete signals
`define CIS_TOP_VALID_MAX 8'hFA
`define CIS_TOP_SPECIAL   8'hFB
`define CIS_TOP_SPEC_MAX  8'hFD
`define CIS_TOP_ERROR     8'hFE
`define CIS_D2_ERROR      4'h2
`define CIS_D4_SPEC_MIN   4'h2
`define CIS_D4_ERROR      4'hE
`define CIS_NORM_ONE      17'h10000

// Time base
`define CIS_CLK_NS        5
`define CIS_MS_NS         1000000

`endif

// >>> cis_pkg.sv
package cis_pkg;

   // Signal kind of one extractor
   typedef enum logic [2:0] {
      CIS_UNDEF,
      CIS_BIT1,
      CIS_BIT2,
      CIS_BIT4,
      CIS_BYTE1,
      CIS_BYTE2,
      CIS_BYTE4
   } cis_kind_t;

   // State of a logical signal
   typedef enum logic [1:0] {
      CIS_VALID,
      CIS_SPECIAL,
      CIS_ERROR,
      CIS_NOT_AVAIL
   } cis_state_t;

   // One received or looped-back CAN frame
   typedef struct packed {
      logic        single;
      logic [17:0] pgn;
      logic [7:0]  src;
      logic [63:0] data;
   } cis_frame_t;

   // Setpoints of one extractor
   typedef struct packed {
      cis_kind_t   kind;
      logic        filt;
      logic [3:0]  byte_pos;
      logic [3:0]  bit_pos;
      logic [7:0]  sel_addr;
      logic [17:0] pgn;
      logic [31:0] res;
      logic [31:0] ofs;
      logic [31:0] max;
      logic [31:0] min;
      logic [13:0] art;
   } cis_cfg_t;

   // Logical output of one extractor
   typedef struct packed {
      cis_state_t  state;
      logic [25:0] code;
      logic [16:0] value;
   } cis_signal_t;

   // All state of one channel
   typedef struct packed {
      cis_cfg_t    cfg;
      cis_signal_t sig;
      logic [13:0] age;
      logic        upd;
   } cis_chan_t;

endpackage

// >>> cis_extractor_assertions.sv
module cis_extractor_assertions
   import cis_pkg::*;
#(
   parameter int unsigned NUM_CH = 5
) (
   input wire logic                     core_clk_in,
   input wire logic                     rst_n_in,
   input wire logic                     psel_in,
   input wire logic                     penable_in,
   input wire logic [31:0]              prdata_out,
   input wire logic                     pready_out,
   input wire logic                     pslverr_out,
   input wire logic                     rx_valid_in,
   input wire logic                     tx_valid_in,
   input wire cis_signal_t [NUM_CH-1:0] sig_out,
   input wire logic [NUM_CH-1:0]        sig_update_out
);
   // Cycles since last frame strobe, saturating
   logic [3:0] since;

   // Loopback may sit one slot behind a bus frame, so allow a short gap
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         since <= 4'hF;
      end else if (rx_valid_in || tx_valid_in) begin
         since <= 4'h0;
      end else if (since != 4'hF) begin
         since <= since + 4'h1;
      end
   end

   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   property p_rdy_after_setup;
      psel_in && !penable_in |=> pready_out;
   endproperty
   a_rdy_after_setup: assert property (p_rdy_after_setup) else $error("no ready after setup");
   property p_rdy_pulse;
      pready_out |=> !pready_out;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
   property p_rdata_idle;
      !pready_out |-> prdata_out == 32'h0 && !pslverr_out;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read bus busy while idle");
   property p_hold;
      !sig_update_out[0] |-> $stable(sig_out[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved without update");
   property p_na_zero;
      sig_out[2].state != CIS_VALID |-> sig_out[2].value == 17'h0;
   endproperty
   a_na_zero: assert property (p_na_zero) else $error("value set in non-valid state");
   property p_clamp;
      sig_out[2].value <= 17'h10000;
   endproperty
   a_clamp: assert property (p_clamp) else $error("value above full scale");
   property p_upd_cause;
      sig_update_out[3] && sig_out[3].state != CIS_NOT_AVAIL |-> since < 4'h3;
   endproperty
   a_upd_cause: assert property (p_upd_cause) else $error("update with no frame");
   property p_reset_na;
      $rose(rst_n_in) |-> sig_out[0].state == CIS_NOT_AVAIL && sig_update_out == '0;
   endproperty
   a_reset_na: assert property (p_reset_na) else $error("output not idle at reset");
endmodule

bind cis_extractor cis_extractor_assertions #(.NUM_CH(NUM_CH)) u_chk (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .rx_valid_in(rx_valid_in), .tx_valid_in(tx_valid_in),
   .sig_out(sig_out), .sig_update_out(sig_update_out)
);

// >>> cis_ecu_model.sv
module cis_ecu_model
   import cis_pkg::*;
(
   input  wire logic core_clk_in,
   output logic      valid_out,
   output cis_frame_t frame_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus idle at start
   initial begin
      valid_out = 1'b0;
      frame_out = '0;
   end

   // One frame after a gap; idle lines show the inverse
   task automatic send(input cis_frame_t f, input int gap);
      repeat (gap + 1) @(posedge core_clk_in);
      valid_out <= 1'b1;
      frame_out <= f;
      @(posedge core_clk_in);
      valid_out <= 1'b0;
      frame_out <= ~f;
   endtask
endmodule

// >>> test_can_input_signal_extractor.sv
`include "cis_defines.svh"
module test_can_input_signal_extractor
   import cis_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam cis_signal_t NA_SIG = '{CIS_NOT_AVAIL, 26'h0, 17'h0};
   localparam logic [31:0] M1     = 32'h00010000;
   localparam logic [31:0] M250   = 32'h00FA0000;
   logic              clk, rst_n, psel, penable, pwrite, pready, pslverr, rxv, txv, er;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [63:0]       d;
   logic [7:0]        sa;
   cis_frame_t        rxf, txf;
   cis_signal_t [4:0] sig;
   logic [4:0]        upd;
   cis_kind_t         ck;
   int                n_mismatch, n_checks, bt, bp;
   logic [7:0]        corner [6] = '{8'h00, 8'hFA, 8'hFB, 8'hFD, 8'hFE, 8'hFF};
   logic [31:0]       wide [8] = '{32'hFE050000, 32'hFB120000, 32'hFF000000, 32'h00100000,
                                   32'hFB000007, 32'hFE000003, 32'hFF123456, 32'h00000002};

   cis_extractor #(.MS_CYCLES(20)) dut (
      .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .rx_valid_in(rxv), .rx_frame_in(rxf),
      .tx_valid_in(txv), .tx_frame_in(txf), .sig_out(sig), .sig_update_out(upd)
   );
   cis_ecu_model ecu (.core_clk_in(clk), .valid_out(rxv), .frame_out(rxf));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic print_verdict();
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_sig(input int ch, input cis_signal_t exp);
      n_checks++;
      if (sig[ch] !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, sig[ch], exp);
      end
   endtask

   // One APB transfer; waits for pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input int ch, input logic [5:0] off, input logic [31:0] v);
      apb(1'b1, 12'(ch * 64 + off), v);
   endtask

   task automatic rdc(input int ch, input logic [5:0] off, input logic [31:0] exp);
      apb(1'b0, 12'(ch * 64 + off), 32'h0);
      chk32(rd, exp);
   endtask

   // Loopback frame from the controller itself
   task automatic txs(input cis_frame_t f);
      @(posedge clk);
      txv <= 1'b1;
      txf <= f;
      @(posedge clk);
      txv <= 1'b0;
      txf <= ~f;
   endtask

   function automatic logic [31:0] cfgw(cis_kind_t k, int p, int b);
      cfgw = {20'h00000, 4'(b), 4'(p), 1'b0, k};
   endfunction

   // Expected output for MIN 0, RES 1, OFS 0
   function automatic cis_signal_t want(cis_kind_t k, logic [63:0] v, int p, int b,
                                        logic [31:0] mx);
      longint r, lo;
      int     w, t;
      want = '0;
      r = longint'(v >> (8 * (p - 1)));
      w = (k == CIS_BIT1) ? 1 : (k == CIS_BIT2) ? 2 : (k == CIS_BIT4) ? 4 :
          (k == CIS_BYTE1) ? 8 : (k == CIS_BYTE2) ? 16 : 32;
      if (w < 8) begin
         r = (r >> (b - 1)) & ((64'h1 << w) - 1);
         if (r < 2) want.value = 17'(r << 16);
         else if ((r == 2 && w == 2) || r == 14) want.state = CIS_ERROR;
         else if ((r == 3 && w == 2) || r == 15) want.state = CIS_NOT_AVAIL;
         else want = '{CIS_SPECIAL, 26'(r - 2), 17'h0};
      end else begin
         r = r & ((64'h1 << w) - 1);
         t = int'(r >> (w - 8));
         lo = r & ((64'h1 << (w - 8)) - 1);
         if (t <= 8'hFA) begin
            lo = (r << 16) / longint'(mx >> 16);
            want.value = 17'((lo > 64'h10000) ? 64'h10000 : lo);
         end else if (t < 8'hFE) want = '{CIS_SPECIAL, 26'(((t - 251) << (w - 8)) | lo), 17'h0};
         else if (t == 8'hFE) want = '{CIS_ERROR, 26'(lo), 17'h0};
         else want.state = CIS_NOT_AVAIL;
      end
   endfunction

   // Frame to channel ch on PGN 0xFF00 + ch
   task automatic hit(input int ch, input cis_kind_t k, input logic [63:0] v, input int p,
                      input int b, input logic [31:0] mx);
      ecu.send({1'b1, 18'h0FF00 + 18'(ch), sa, v}, $urandom_range(2));
      #1;
      chk32(32'(upd), 32'(1 << ch));
      chk_sig(ch, want(k, v, p, b, mx));
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end

   // Main sequence
   initial begin
      n_mismatch = 0;
      n_checks = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      txv = 1'b0;
      txf = '0;
      sa = 8'h00;
      void'($urandom(32'hBD68));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rdc(0, `CIS_OFF_CFG, 32'h00000110);
      rdc(0, `CIS_OFF_PGN, 32'h0000FF00);
      rdc(0, `CIS_OFF_ART, 32'h000001F4);
      rdc(4, `CIS_OFF_STATUS, 32'h00000003);
      rdc(4, `CIS_OFF_RES, M1);
      apb(1'b0, 12'h140, 32'h0);
      chk32(32'(er), 32'h1);
      // Undefined kind ignores frames
      ecu.send({1'b1, 18'h0FF00, 8'h05, 64'h1}, 0);
      #1;
      chk32(32'(upd), 32'h0);
      wr(0, `CIS_OFF_CFG, cfgw(CIS_BYTE1, 3, 1));
      wr(0, `CIS_OFF_MAX, M250);
      wr(1, `CIS_OFF_PGN, 32'h0000FF01);
      wr(2, `CIS_OFF_PGN, 32'h0000FF02);
      wr(3, `CIS_OFF_PGN, 32'h00001234);
      wr(3, `CIS_OFF_CFG, cfgw(CIS_BYTE1, 1, 1));
      wr(3, `CIS_OFF_ART, 32'h0);
      // Range corners first, then random codes
      for (int i = 0; i < 40; i++) begin
         d = {$urandom, $urandom};
         if (i < 6) d[23:16] = corner[i];
         sa = 8'($urandom);
         hit(0, CIS_BYTE1, d, 3, 1, M250);
      end
      // Multi-frame, foreign PGN: no change
      ecu.send({1'b0, 18'h0FF00, 8'h05, d}, 1);
      #1;
      chk32(32'(upd), 32'h0);
      ecu.send({1'b1, 18'h3FFFF, 8'h05, d}, 0);
      #1;
      chk32(32'(upd), 32'h0);
      chk_sig(0, want(CIS_BYTE1, d, 3, 1, M250));
      // Filter on; address clamps to 253
      wr(0, `CIS_OFF_CFG, 32'h00FF013C);
      rdc(0, `CIS_OFF_CFG, 32'h00FD013C);
      ecu.send({1'b1, 18'h0FF00, 8'h22, d}, 0);
      #1;
      chk32(32'(upd), 32'h0);
      sa = 8'hFD;
      hit(0, CIS_BYTE1, ~d, 3, 1, M250);
      // Discrete fields at top of byte 8, every code
      for (int k = 1; k < 4; k++) begin
         bt = 9 - (1 << (k - 1));
         wr(1, `CIS_OFF_CFG, cfgw(cis_kind_t'(k), 8, bt));
         for (int i = 0; i < 16; i++)
            hit(1, cis_kind_t'(k), {4'(i), 28'($urandom), $urandom}, 8, bt, M1);
      end
      // Wide continuous kinds ending at byte 8
      for (int i = 0; i < 8; i++) begin
         ck = (i < 4) ? CIS_BYTE2 : CIS_BYTE4;
         bp = (i < 4) ? 7 : 5;
         wr(2, `CIS_OFF_CFG, cfgw(ck, bp, 1));
         hit(2, ck, {wide[i], $urandom}, bp, 1, M1);
      end
      // Scale 2.0, offset 1.0, span 16.0
      wr(2, `CIS_OFF_RES, 32'h00020000);
      wr(2, `CIS_OFF_OFS, 32'h00010000);
      wr(2, `CIS_OFF_MAX, 32'h00100000);
      ecu.send({1'b1, 18'h0FF02, sa, 64'h0000000500000000}, 0);
      #1;
      chk_sig(2, cis_signal_t'{CIS_VALID, 26'h0, 17'((2 * 5 + 1) * 65536 / 16)});
      // Loopback meets a bus frame: bus first
      fork
         ecu.send({1'b1, 18'h0FF00, 8'hFD, d}, 0);
         txs({1'b1, 18'h01234, 8'h80, 64'hFE});
      join
      #1;
      chk32(32'(upd), 32'h1);
      @(posedge clk);
      #1;
      chk32(32'(upd), 32'h8);
      chk_sig(3, want(CIS_BYTE1, 64'hFE, 1, 1, M1));
      txs({1'b1, 18'h01234, 8'h80, 64'h0});
      #1;
      chk_sig(3, want(CIS_BYTE1, 64'h0, 1, 1, M1));
      // Timeout 3 ms, restarted by a fresh frame
      wr(0, `CIS_OFF_ART, 32'h3);
      d = 64'h0000000000320000;
      hit(0, CIS_BYTE1, d, 3, 1, M250);
      repeat (35) @(posedge clk);
      #1;
      chk_sig(0, want(CIS_BYTE1, d, 3, 1, M250));
      hit(0, CIS_BYTE1, d, 3, 1, M250);
      repeat (35) @(posedge clk);
      #1;
      chk_sig(0, want(CIS_BYTE1, d, 3, 1, M250));
      repeat (30) @(posedge clk);
      #1;
      chk_sig(0, NA_SIG);
      // Short timeout expires; zero never does
      wr(2, `CIS_OFF_ART, 32'h1);
      repeat (25) @(posedge clk);
      #1;
      chk_sig(2, NA_SIG);
      chk_sig(3, want(CIS_BYTE1, 64'h0, 1, 1, M1));
      print_verdict();
   end
endmodule
